// >>> core/sac_map.svh
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
// Register byte offsets
`define SAC_OFS_CTRL1    12'h000
`define SAC_OFS_CTRL2    12'h004
`define SAC_OFS_RESULT   12'h008
`define SAC_OFS_CMPVAL   12'h00c
`define SAC_OFS_CONFIG   12'h010
`define SAC_OFS_PINEN1   12'h014
`define SAC_OFS_PINEN2   12'h018
`define SAC_OFS_RTC      12'h01c
`define SAC_OFS_MODE     12'h020
// Field positions
`define SAC_C1_DONE      7
`define SAC_C1_IEN       6
`define SAC_C1_CONT      5
`define SAC_C2_ACTIVE    7
`define SAC_C2_TRIG      6
`define SAC_C2_CMPEN     5
`define SAC_C2_CMPGE     4
`define SAC_CFG_LP       7
`define SAC_CFG_LONG     4
`define SAC_MODE_WAIT    0
`define SAC_MODE_STOP3   1
// Channel codes
`define SAC_CH_EXT_LAST  5'h0b
`define SAC_CH_LOWREF_LO 5'h0c
`define SAC_CH_LOWREF_HI 5'h14
`define SAC_CH_TEMP      5'h1a
`define SAC_CH_BANDGAP   5'h1b
`define SAC_CH_RSV       5'h1c
`define SAC_CH_HIREF     5'h1d
`define SAC_CH_LOWREF    5'h1e
`define SAC_CH_OFF       5'h1f
// Reset values
`define SAC_RST_CH       5'h1f
// Timing in conversion clock cycles
`define SAC_SAMPLE_SHORT 5'h03
`define SAC_SAMPLE_LONG  5'h17
`define SAC_BIT_FAST     2'h0
`define SAC_BIT_SLOW     2'h1
`define SAC_RES_BITS     4'hc
`endif

// >>> core/sac_pkg.sv
package sac_pkg;
  typedef enum logic [2:0] {
    SAC_SRC_PIN    = 3'h0,
    SAC_SRC_LOWREF = 3'h1,
    SAC_SRC_TEMP   = 3'h2,
    SAC_SRC_BGAP   = 3'h3,
    SAC_SRC_HIREF  = 3'h4,
    SAC_SRC_RSV    = 3'h5,
    SAC_SRC_OFF    = 3'h6
  } sac_src_t;
  typedef struct packed {
    sac_src_t   src;
    logic [3:0] pin;
  } sac_chan_t;
  typedef enum logic [1:0] {
    SAC_MODE_12 = 2'h1,
    SAC_MODE_10 = 2'h2,
    SAC_MODE_8  = 2'h0
  } sac_width_t;
  typedef enum logic [1:0] {
    SAC_CLK_BUS    = 2'h0,
    SAC_CLK_BUS2   = 2'h1,
    SAC_CLK_ALT    = 2'h2,
    SAC_CLK_LOCAL  = 2'h3
  } sac_clksrc_t;
  typedef struct packed {
    logic        low_power;
    logic [1:0]  div_sel;
    logic        long_sample;
    sac_width_t  width;
    sac_clksrc_t clk_src;
  } sac_cfg_t;
endpackage : sac_pkg

// >>> core/sac_chan_dec.sv
`timescale 1ns/10ps
`include "sac_map.svh"
module sac_chan_dec (
  input  wire logic [4:0]        channel_select_i, // Channel code
  output sac_pkg::sac_chan_t     chan_o            // Decoded selection
);
  always_comb begin
    chan_o.pin = channel_select_i[3:0];
    if (channel_select_i <= `SAC_CH_EXT_LAST) begin
      chan_o.src = sac_pkg::SAC_SRC_PIN;
    end else if (channel_select_i <= `SAC_CH_LOWREF_HI) begin
      chan_o.src = sac_pkg::SAC_SRC_LOWREF;
    end else begin
      unique case (channel_select_i)
        `SAC_CH_TEMP:    chan_o.src = sac_pkg::SAC_SRC_TEMP;
        `SAC_CH_BANDGAP: chan_o.src = sac_pkg::SAC_SRC_BGAP;
        `SAC_CH_HIREF:   chan_o.src = sac_pkg::SAC_SRC_HIREF;
        `SAC_CH_LOWREF:  chan_o.src = sac_pkg::SAC_SRC_LOWREF;
        `SAC_CH_OFF:     chan_o.src = sac_pkg::SAC_SRC_OFF;
        default:         chan_o.src = sac_pkg::SAC_SRC_RSV;
      endcase
    end
  end
endmodule : sac_chan_dec

// >>> core/sac_clk_div.sv
`timescale 1ns/10ps
`include "sac_map.svh"
// Produces a one-cycle tick per conversion clock period.
module sac_clk_div (
  input  wire logic              clock_i,       // System clock
  input  wire logic              reset_i,       // Sync reset, high
  input  wire sac_pkg::sac_clksrc_t clk_src_i,  // Source select
  input  wire logic [1:0]        div_sel_i,     // Divide by 1,2,4,8
  input  wire logic              alt_tick_i,    // Alternate clock tick
  input  wire logic              local_tick_i,  // Local async clock tick
  output logic                   tick_o         // Conversion clock tick
);
  logic       half_q, half_d;
  logic [2:0] cnt_q, cnt_d;
  logic       src_tick;
  logic [2:0] limit;

  always_comb begin
    half_d = ~half_q;
    unique case (clk_src_i)
      sac_pkg::SAC_CLK_BUS:   src_tick = 1'b1;
      sac_pkg::SAC_CLK_BUS2:  src_tick = half_q;
      sac_pkg::SAC_CLK_ALT:   src_tick = alt_tick_i;
      sac_pkg::SAC_CLK_LOCAL: src_tick = local_tick_i;
    endcase
    limit  = 3'((4'h1 << div_sel_i) - 4'h1);
    cnt_d  = cnt_q;
    tick_o = 1'b0;
    if (src_tick) begin
      if (cnt_q >= limit) begin
        cnt_d  = 3'h0;
        tick_o = 1'b1;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      half_q <= 1'b0;
      cnt_q  <= 3'h0;
    end else begin
      half_q <= half_d;
      cnt_q  <= cnt_d;
    end
  end
endmodule : sac_clk_div

// >>> core/sac_adc_ctrl.sv
`timescale 1ns/10ps
`include "sac_map.svh"
// How it works
// - Codes 0-11 pick pins, 12-20 low ref, then temp, bandgap, refs, off.
// - Reserved codes still convert; the result is undefined.
// - Conversion clock comes from bus, bus/2, local or alternate clock.
// - The selected source is divided by the divide field; software keeps range.
// - The alternate clock keeps timing conversions during wait mode.
// - In hardware trigger mode a counter match starts a conversion.
// - The match triggers regardless of the counter's interrupt enable.
// - The hardware trigger works in run, wait and stop3.
// - A linear successive approximation resolves twelve bits.
// - Results are right-justified unsigned, 12, 10 or 8 bits wide.
// - Single or continuous; a single conversion returns to idle itself.
// - Completion sets the done flag and interrupts when enabled.
// - Optional compare, less-than or greater-or-equal, gates the flag.
// - Sample time and speed/power are software settings.
// - Only two pin enable registers exist.
// - Writing control one aborts, and restarts unless the channel is off or hardware trigger is set.
// - Done flag clears on control one write or result read.
module sac_adc_ctrl (
  input  wire logic        clock_i,        // 250 MHz bus clock
  input  wire logic        reset_i,        // Sync reset, high
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [11:0] paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic             pready,         // APB ready
  output logic [31:0]      prdata,         // APB read data
  output logic             pslverr,        // APB error
  input  wire logic [15:0] rtc_count_value_i,  // Real-time counter value
  input  wire logic [15:0] rtc_modulo_value_i, // Real-time counter modulo
  input  wire logic        alt_tick_i,     // Alternate clock tick
  input  wire logic        local_tick_i,   // Local async clock tick
  input  wire logic        comp_i,         // Analog comparator, 1 = input above DAC
  output logic [11:0]      dac_o,          // Trial value to the analog DAC
  output logic [4:0]       mux_sel_o,      // Analog mux select
  output logic             sample_o,       // Sampling switch closed
  output logic             analog_on_o,    // Analog core powered
  output logic             low_power_o,    // Low power bias
  output logic [15:0]      pin_enable_o,   // Analog pin enables
  output logic             irq_o           // Completion interrupt
);
  typedef enum logic [1:0] {
    SAC_IDLE   = 2'h0,
    SAC_SAMPLE = 2'h1,
    SAC_CONV   = 2'h2
  } sac_state_t;

  sac_pkg::sac_chan_t chan;
  sac_pkg::sac_cfg_t  cfg_q, cfg_d;
  sac_state_t         state_q, state_d;
  logic [4:0]  ch_q, ch_d;
  logic        ien_q, ien_d, cont_q, cont_d, done_q, done_d;
  logic        trig_q, trig_d, cmpen_q, cmpen_d, cmpge_q, cmpge_d;
  logic [11:0] cmpval_q, cmpval_d, res_q, res_d, sar_q, sar_d;
  logic [7:0]  pin1_q, pin1_d, pin2_q, pin2_d;
  logic        wait_q, wait_d, stop3_q, stop3_d;
  logic [3:0]  bit_q, bit_d;
  logic [4:0]  tcnt_q, tcnt_d;
  logic        match_q, match_d;
  logic        tick, wr, rd, hw_start, start, restart, ch_off, cmp_ok;
  logic [11:0] final_val;

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] ofs);
    is_addr = (a == ofs);
  endfunction : is_addr

  // Truncates the 12-bit code to the chosen width, right-justified
  function automatic logic [11:0] fmt(input logic [11:0] v, input sac_pkg::sac_width_t w);
    unique case (w)
      sac_pkg::SAC_MODE_12: fmt = v;
      sac_pkg::SAC_MODE_10: fmt = {2'h0, v[11:2]};
      sac_pkg::SAC_MODE_8:  fmt = {4'h0, v[11:4]};
      default:              fmt = v;
    endcase
  endfunction : fmt

  sac_chan_dec u_dec (
    .channel_select_i (ch_q),
    .chan_o           (chan)
  );

  sac_clk_div u_div (
    .clock_i      (clock_i),
    .reset_i      (reset_i),
    .clk_src_i    (cfg_q.clk_src),
    .div_sel_i    (cfg_q.div_sel),
    .alt_tick_i   (alt_tick_i),
    .local_tick_i (local_tick_i),
    .tick_o       (tick)
  );

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign ch_off  = (ch_q == `SAC_CH_OFF);

  // Level compare gives a match every count cycle; only the rising edge starts.
  always_comb begin
    match_d  = (rtc_count_value_i == rtc_modulo_value_i);
    hw_start = trig_q & match_d & ~match_q & ~ch_off;
  end

  // Register file
  always_comb begin
    cfg_d    = cfg_q;
    ch_d     = ch_q;
    ien_d    = ien_q;
    cont_d   = cont_q;
    trig_d   = trig_q;
    cmpen_d  = cmpen_q;
    cmpge_d  = cmpge_q;
    cmpval_d = cmpval_q;
    pin1_d   = pin1_q;
    pin2_d   = pin2_q;
    wait_d   = wait_q;
    stop3_d  = stop3_q;
    restart  = 1'b0;
    if (wr) begin
      if (is_addr(paddr, `SAC_OFS_CTRL1)) begin
        ien_d   = pwdata[`SAC_C1_IEN];
        cont_d  = pwdata[`SAC_C1_CONT];
        ch_d    = pwdata[4:0];
        restart = 1'b1;
      end
      if (is_addr(paddr, `SAC_OFS_CTRL2)) begin
        trig_d  = pwdata[`SAC_C2_TRIG];
        cmpen_d = pwdata[`SAC_C2_CMPEN];
        cmpge_d = pwdata[`SAC_C2_CMPGE];
      end
      if (is_addr(paddr, `SAC_OFS_CMPVAL)) cmpval_d = pwdata[11:0];
      if (is_addr(paddr, `SAC_OFS_CONFIG)) cfg_d = pwdata[7:0];
      if (is_addr(paddr, `SAC_OFS_PINEN1)) pin1_d = pwdata[7:0];
      if (is_addr(paddr, `SAC_OFS_PINEN2)) pin2_d = pwdata[7:0];
      if (is_addr(paddr, `SAC_OFS_MODE)) begin
        wait_d  = pwdata[`SAC_MODE_WAIT];
        stop3_d = pwdata[`SAC_MODE_STOP3];
      end
    end
  end

  always_comb begin
    prdata = 32'h0;
    if (rd) begin
      if (is_addr(paddr, `SAC_OFS_CTRL1)) begin
        prdata = {24'h0, done_q, ien_q, cont_q, ch_q};
      end else if (is_addr(paddr, `SAC_OFS_CTRL2)) begin
        prdata = {24'h0, (state_q != SAC_IDLE), trig_q, cmpen_q, cmpge_q, 4'h0};
      end else if (is_addr(paddr, `SAC_OFS_RESULT)) begin
        prdata = {20'h0, res_q};
      end else if (is_addr(paddr, `SAC_OFS_CMPVAL)) begin
        prdata = {20'h0, cmpval_q};
      end else if (is_addr(paddr, `SAC_OFS_CONFIG)) begin
        prdata = {24'h0, cfg_q};
      end else if (is_addr(paddr, `SAC_OFS_PINEN1)) begin
        prdata = {24'h0, pin1_q};
      end else if (is_addr(paddr, `SAC_OFS_PINEN2)) begin
        prdata = {24'h0, pin2_q};
      end else if (is_addr(paddr, `SAC_OFS_RTC)) begin
        prdata = {rtc_modulo_value_i, rtc_count_value_i};
      end else if (is_addr(paddr, `SAC_OFS_MODE)) begin
        prdata = {30'h0, stop3_q, wait_q};
      end
    end
  end

  // Conversion sequencer
  always_comb begin
    state_d   = state_q;
    sar_d     = sar_q;
    bit_d     = bit_q;
    tcnt_d    = tcnt_q;
    res_d     = res_q;
    done_d    = done_q;
    start     = restart ? (ch_d != `SAC_CH_OFF) : hw_start;
    final_val = fmt(sar_q, cfg_q.width);
    cmp_ok    = cmpge_q ? (final_val >= cmpval_q) : (final_val < cmpval_q);
    if (restart && trig_q) begin
      start = 1'b0;
    end
    // In trigger mode a write still aborts, then waits for the next match
    if (restart && ((ch_d == `SAC_CH_OFF) || trig_q)) begin
      state_d = SAC_IDLE;
    end else if (start) begin
      state_d = SAC_SAMPLE;
      tcnt_d  = cfg_q.long_sample ? `SAC_SAMPLE_LONG : `SAC_SAMPLE_SHORT;
      sar_d   = 12'h0;
      bit_d   = `SAC_RES_BITS;
    end else if (tick) begin
      unique case (state_q)
        SAC_IDLE: ;
        SAC_SAMPLE: begin
          if (tcnt_q == 5'h0) begin
            state_d = SAC_CONV;
            sar_d   = 12'h800;
            // Reload here so a continuous rerun resolves all twelve bits
            bit_d   = `SAC_RES_BITS;
            tcnt_d  = {3'h0, cfg_q.low_power ? `SAC_BIT_SLOW : `SAC_BIT_FAST};
          end else begin
            tcnt_d = tcnt_q - 5'h1;
          end
        end
        SAC_CONV: begin
          if (tcnt_q != 5'h0) begin
            tcnt_d = tcnt_q - 5'h1;
          end else begin
            // Keep or drop the trial bit, then try the next lower one
            sar_d  = sar_q & ~(comp_i ? 12'h0 : (12'h800 >> (4'hc - bit_q)));
            sar_d  = sar_d | ((bit_q > 4'h1) ? (12'h800 >> (4'hd - bit_q)) : 12'h0);
            bit_d  = bit_q - 4'h1;
            tcnt_d = {3'h0, cfg_q.low_power ? `SAC_BIT_SLOW : `SAC_BIT_FAST};
            if (bit_q == 4'h1) begin
              state_d = cont_q ? SAC_SAMPLE : SAC_IDLE;
              tcnt_d  = cfg_q.long_sample ? `SAC_SAMPLE_LONG : `SAC_SAMPLE_SHORT;
            end
          end
        end
        default: state_d = SAC_IDLE;
      endcase
    end
    // Result captured the cycle the last bit resolves
    if (state_q == SAC_CONV && state_d != SAC_CONV && !start && !restart) begin
      final_val = fmt(sar_d, cfg_q.width);
      cmp_ok    = cmpge_q ? (final_val >= cmpval_q) : (final_val < cmpval_q);
      if (!cmpen_q || cmp_ok) begin
        res_d  = final_val;
        done_d = 1'b1;
      end
    end else if (restart || (rd && is_addr(paddr, `SAC_OFS_RESULT))) begin
      done_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_q  <= SAC_IDLE;
      cfg_q    <= '0;
      ch_q     <= `SAC_RST_CH;
      ien_q    <= 1'b0;
      cont_q   <= 1'b0;
      done_q   <= 1'b0;
      trig_q   <= 1'b0;
      cmpen_q  <= 1'b0;
      cmpge_q  <= 1'b0;
      cmpval_q <= 12'h0;
      res_q    <= 12'h0;
      sar_q    <= 12'h0;
      pin1_q   <= 8'h0;
      pin2_q   <= 8'h0;
      wait_q   <= 1'b0;
      stop3_q  <= 1'b0;
      bit_q    <= 4'h0;
      tcnt_q   <= 5'h0;
      match_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      cfg_q    <= cfg_d;
      ch_q     <= ch_d;
      ien_q    <= ien_d;
      cont_q   <= cont_d;
      done_q   <= done_d;
      trig_q   <= trig_d;
      cmpen_q  <= cmpen_d;
      cmpge_q  <= cmpge_d;
      cmpval_q <= cmpval_d;
      res_q    <= res_d;
      sar_q    <= sar_d;
      pin1_q   <= pin1_d;
      pin2_q   <= pin2_d;
      wait_q   <= wait_d;
      stop3_q  <= stop3_d;
      bit_q    <= bit_d;
      tcnt_q   <= tcnt_d;
      match_q  <= match_d;
    end
  end

  // Analog side follows the registered state
  always_comb begin
    dac_o        = sar_q;
    mux_sel_o    = ch_q;
    sample_o     = (state_q == SAC_SAMPLE);
    analog_on_o  = (state_q != SAC_IDLE) && (chan.src != sac_pkg::SAC_SRC_OFF);
    low_power_o  = cfg_q.low_power;
    pin_enable_o = {pin2_q, pin1_q};
    irq_o        = done_q & ien_q;
  end
endmodule : sac_adc_ctrl

// >>> sim/sac_adc_ctrl_asserts.sv
`timescale 1ns/10ps
`include "sac_map.svh"
module sac_adc_ctrl_asserts (
  input  wire logic        clock_i,      // Clock
  input  wire logic        reset_i,      // Reset
  input  wire logic        psel,         // Select
  input  wire logic        penable,      // Enable
  input  wire logic        pwrite,       // Direction
  input  wire logic [11:0] paddr,        // Address
  input  wire logic [31:0] pwdata,       // Write data
  input  wire logic        pready,       // Ready
  input  wire logic [31:0] prdata,       // Read data
  input  wire logic        pslverr,      // Error
  input  wire logic [4:0]  mux_sel_o,    // Mux select
  input  wire logic        sample_o,     // Sampling
  input  wire logic        analog_on_o,  // Analog on
  input  wire logic        low_power_o,  // Low power
  input  wire logic [15:0] pin_enable_o, // Pin enables
  input  wire logic        irq_o         // Interrupt
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  wire wr_ac = psel & penable & pwrite;
  property p_ready; pready && !pslverr; endproperty
  a_ready: assert property (p_ready) else $error("slave not ready or error");
  property p_idle; !(psel && penable) |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  property p_mux; wr_ac && paddr == `SAC_OFS_CTRL1 |=> mux_sel_o == $past(pwdata[4:0]); endproperty
  a_mux: assert property (p_mux) else $error("mux select not from write");
  property p_off; mux_sel_o == 5'h1f ##1 mux_sel_o == 5'h1f |-> !analog_on_o && !sample_o;
  endproperty
  a_off: assert property (p_off) else $error("converter active while off");
  property p_irq; wr_ac && paddr == `SAC_OFS_CTRL1 && !pwdata[6] |=> !irq_o; endproperty
  a_irq: assert property (p_irq) else $error("interrupt with enable clear");
  property p_pin; wr_ac && paddr == `SAC_OFS_PINEN1 |=> pin_enable_o[7:0] == $past(pwdata[7:0]);
  endproperty
  a_pin: assert property (p_pin) else $error("pin enables not updated");
  property p_lp; wr_ac && paddr == `SAC_OFS_CONFIG |=> low_power_o == $past(pwdata[7]); endproperty
  a_lp: assert property (p_lp) else $error("low power bit not updated");
  property p_rst; disable iff (1'b0) reset_i |=> mux_sel_o == 5'h1f && !irq_o && !sample_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : sac_adc_ctrl_asserts

bind sac_adc_ctrl sac_adc_ctrl_asserts sac_adc_ctrl_asserts_i (
  .clock_i(clock_i), .reset_i(reset_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .mux_sel_o(mux_sel_o), .sample_o(sample_o), .analog_on_o(analog_on_o),
  .low_power_o(low_power_o), .pin_enable_o(pin_enable_o), .irq_o(irq_o));

// >>> sim/sac_analog_model.sv
`timescale 1ns/10ps
module sac_analog_model (
  input  wire logic        clock_i,     // Clock
  input  wire logic        reset_i,     // Reset
  input  wire logic        rtc_run_i,   // Counter running
  input  wire logic [4:0]  mux_sel_i,   // Channel
  input  wire logic [11:0] dac_i,       // Trial code
  output logic             comp_o,      // Comparator
  output logic [15:0]      rtc_count_o, // Counter value
  output logic [15:0]      rtc_mod_o    // Counter modulo
);
  logic [11:0] level;
  always_comb begin
    if (mux_sel_i == 5'h1d) begin
      level = 12'hfff;
    end else if ((mux_sel_i >= 5'h0c && mux_sel_i <= 5'h14) || mux_sel_i == 5'h1e) begin
      level = 12'h000;
    end else begin
      level = {mux_sel_i, 7'h2b};
    end
  end
  // Ideal comparator so a correct search lands exactly on the level
  assign comp_o    = level >= dac_i;
  assign rtc_mod_o = 16'h00ff;
  // Counter has no interrupt enable at all; matches still reach the converter
  always_ff @(posedge clock_i) begin
    if (reset_i || rtc_count_o == rtc_mod_o) begin
      rtc_count_o <= 16'h0000;
    end else if (rtc_run_i) begin
      rtc_count_o <= rtc_count_o + 16'h0001;
    end
  end
endmodule : sac_analog_model

// >>> sim/sac_adc_ctrl_tb_top.sv
`timescale 1ns/10ps
`include "sac_map.svh"
module sac_adc_ctrl_tb_top;
  logic        clock_i, reset_i, psel, penable, pwrite, pready, pslverr, comp;
  logic        alt_tick, local_tick, rtc_run, alt_run, sample, aon, lp, irq;
  logic [11:0] paddr, dac;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] rtc_cnt, rtc_mod, pins;
  logic [4:0]  mux;
  int          n_mismatch, n_compared;

  sac_adc_ctrl sac_adc_ctrl_i (.clock_i(clock_i), .reset_i(reset_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .rtc_count_value_i(rtc_cnt),
    .rtc_modulo_value_i(rtc_mod), .alt_tick_i(alt_tick), .local_tick_i(local_tick),
    .comp_i(comp), .dac_o(dac), .mux_sel_o(mux), .sample_o(sample), .analog_on_o(aon),
    .low_power_o(lp), .pin_enable_o(pins), .irq_o(irq));
  sac_analog_model sac_analog_model_i (.clock_i(clock_i), .reset_i(reset_i),
    .rtc_run_i(rtc_run), .mux_sel_i(mux), .dac_i(dac), .comp_o(comp),
    .rtc_count_o(rtc_cnt), .rtc_mod_o(rtc_mod));

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    local_tick <= ~local_tick;
    alt_tick   <= alt_run & ~alt_tick;
  end

  function automatic logic [31:0] lvl(input logic [4:0] c);
    if (c == 5'h1d) return 32'hfff;
    if ((c >= 5'h0c && c <= 5'h14) || c == 5'h1e) return 32'h0;
    return {20'h0, c, 7'h2b};
  endfunction

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
    if (n >= 20) begin
      n_mismatch++;
      close_out();
    end
  endtask : apb

  // Polls the done flag; a missing required completion ends the run
  task automatic poll(input int lim, input logic want);
    int n;
    n = 0;
    do begin
      apb(1'b0, `SAC_OFS_CTRL1, 32'h0);
      n++;
    end while (r[7] !== 1'b1 && n < lim);
    chk({31'h0, r[7]}, {31'h0, want});
    if (r[7] !== 1'b1 && want) close_out();
  endtask : poll

  task automatic conv(input logic [31:0] c1);
    apb(1'b1, `SAC_OFS_CTRL1, c1);
    poll(300, 1'b1);
    apb(1'b0, `SAC_OFS_RESULT, 32'h0);
  endtask : conv

  task automatic s_reset();
    apb(1'b0, `SAC_OFS_CTRL1, 32'h0);
    chk(r, 32'h1f);
    chk({27'h0, mux}, 32'h1f);
    apb(1'b1, 12'h100, 32'hffff_ffff);
    apb(1'b0, 12'h100, 32'h0);
    chk(r, 32'h0);
  endtask : s_reset

  // Bandgap buffer taken as enabled by the system before code 1b
  task automatic s_chan();
    logic [4:0] c[11] = '{5'h00, 5'h05, 5'h0b, 5'h0c, 5'h14, 5'h1a, 5'h1b, 5'h1d, 5'h1e,
                          5'h15, 5'h1c};
    apb(1'b1, `SAC_OFS_CONFIG, 32'h4);
    foreach (c[i]) begin
      conv({27'h0, c[i]});
      if (i < 9) chk(r, lvl(c[i]));
      chk({31'h0, aon}, 32'h0);
      apb(1'b0, `SAC_OFS_CTRL1, 32'h0);
      chk(r, {27'h0, c[i]});
    end
  endtask : s_chan

  task automatic s_fmt();
    logic [31:0] cfg[5] = '{32'h08, 32'h00, 32'h05, 32'h26, 32'h07};
    logic [31:0] exp[5] = '{32'h0aa, 32'h02a, 32'h2ab, 32'h2ab, 32'h2ab};
    alt_run <= 1'b1;
    apb(1'b1, `SAC_OFS_MODE, 32'h1);
    foreach (cfg[i]) begin
      apb(1'b1, `SAC_OFS_CONFIG, cfg[i]);
      conv(32'h05);
      chk(r, exp[i]);
    end
    apb(1'b1, `SAC_OFS_CONFIG, 32'h64);
    apb(1'b1, `SAC_OFS_CTRL1, 32'h05);
    poll(20, 1'b0);
    poll(300, 1'b1);
    alt_run <= 1'b0;
    apb(1'b1, `SAC_OFS_CONFIG, 32'h06);
    apb(1'b1, `SAC_OFS_CTRL1, 32'h05);
    poll(15, 1'b0);
    alt_run <= 1'b1;
    poll(300, 1'b1);
    apb(1'b1, `SAC_OFS_MODE, 32'h0);
  endtask : s_fmt

  task automatic s_cmp();
    apb(1'b1, `SAC_OFS_CONFIG, 32'h4);
    apb(1'b1, `SAC_OFS_CMPVAL, 32'h2ac);
    apb(1'b1, `SAC_OFS_CTRL2, 32'h30);
    apb(1'b1, `SAC_OFS_CTRL1, 32'h45);
    poll(60, 1'b0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `SAC_OFS_CMPVAL, 32'h2ab);
    apb(1'b1, `SAC_OFS_CTRL1, 32'h45);
    poll(300, 1'b1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `SAC_OFS_CTRL2, 32'h20);
    apb(1'b1, `SAC_OFS_CMPVAL, 32'h2ac);
    conv(32'h05);
    chk(r, 32'h2ab);
    apb(1'b1, `SAC_OFS_CTRL2, 32'h0);
  endtask : s_cmp

  task automatic s_cont();
    conv(32'h25);
    chk(r, 32'h2ab);
    poll(300, 1'b1);
    apb(1'b0, `SAC_OFS_RESULT, 32'h0);
    chk(r, 32'h2ab);
    apb(1'b1, `SAC_OFS_CTRL1, 32'h3f);
    poll(60, 1'b0);
    chk({31'h0, aon}, 32'h0);
    apb(1'b1, `SAC_OFS_CTRL1, 32'h05);
    conv(32'h1d);
    chk(r, 32'hfff);
  endtask : s_cont

  // Bus clock, not the alternate one, while in stop3
  task automatic s_trig();
    apb(1'b1, `SAC_OFS_MODE, 32'h2);
    apb(1'b1, `SAC_OFS_CTRL2, 32'h40);
    apb(1'b1, `SAC_OFS_CTRL1, 32'h0b);
    poll(30, 1'b0);
    rtc_run <= 1'b1;
    poll(300, 1'b1);
    rtc_run <= 1'b0;
    apb(1'b0, `SAC_OFS_RESULT, 32'h0);
    chk(r, 32'h5ab);
    apb(1'b1, `SAC_OFS_CTRL2, 32'h0);
  endtask : s_trig

  task automatic s_regs();
    apb(1'b1, `SAC_OFS_PINEN1, 32'ha5);
    apb(1'b1, `SAC_OFS_PINEN2, 32'h3c);
    chk({16'h0, pins}, 32'h3ca5);
    apb(1'b1, `SAC_OFS_CONFIG, 32'h84);
    chk({31'h0, lp}, 32'h1);
    conv(32'h1a);
    chk(r, lvl(5'h1a));
    // Long sample: 24 ticks of sampling keep the flag low past 8 polls
    apb(1'b1, `SAC_OFS_CONFIG, 32'h14);
    apb(1'b1, `SAC_OFS_CTRL1, 32'h05);
    poll(8, 1'b0);
    poll(300, 1'b1);
    apb(1'b0, `SAC_OFS_RESULT, 32'h0);
    chk(r, 32'h2ab);
  endtask : s_regs

  initial begin
    reset_i    = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    local_tick = 1'b0;
    alt_tick   = 1'b0;
    alt_run    = 1'b0;
    rtc_run    = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    s_reset();
    s_chan();
    s_fmt();
    s_cmp();
    s_cont();
    s_trig();
    s_regs();
    close_out();
  end
endmodule : sac_adc_ctrl_tb_top
